// File: src/packet_ram.sv
// Control packet store in flip-flops, one parity bit per entry.
// Assumes one write port and one read port on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "timer_transfer_params.svh"
module packet_ram #(
  parameter int DEPTH = `NUM_PACKETS,
  parameter int WIDTH = `PKT_WIDTH
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_index,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_index,
  output logic [WIDTH-1:0] rd_data,
  output logic parity_error
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH:0] entry;
  } ram_state_type;
  ram_state_type state;
  ram_state_type next_state;
  logic [WIDTH:0] word;
  always_comb begin
    next_state = state;
    if (wr_en) begin
      next_state.entry[wr_index] = {^wr_data, wr_data};
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= '0;
    end else if (ce) begin
      state <= next_state;
    end
  end
  assign word = state.entry[rd_index];
  assign rd_data = word[WIDTH-1:0];
  // Even parity over data plus stored bit; a cleared entry checks clean
  assign parity_error = ^word;
endmodule : packet_ram
`default_nettype wire

// File: src/sync2.sv
// Two-stage synchroniser for a vector of pin-side levels.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_type;
  sync_state_type state;
  sync_state_type next_state;
  always_comb begin
    next_state.stage1 = async_in;
    next_state.stage2 = state.stage1;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // Idle high so fault inputs do not disable outputs out of reset
      state <= '1;
    end else if (ce) begin
      state <= next_state;
    end
  end
  assign sync_out = state.stage2;
endmodule : sync2
`default_nettype wire

// File: src/timer_transfer_params.svh
// Constants for the timer transfer unit and its fault and clock-monitor hookups.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef TIMER_TRANSFER_PARAMS_SVH
`define TIMER_TRANSFER_PARAMS_SVH
`define NUM_PACKETS 8
`define NUM_CH_FIRST 32
`define NUM_CH_SECOND 32
`define PIN_DISABLE_BIT_A 5
`define PIN_DISABLE_BIT_B 2
`define MONITOR_CH_FIRST 31
`define MONITOR_CH_SECOND 0
`define TIMER_STEP_SMALL 8
`define TIMER_STEP_LARGE 16
`define MEM_STEP_32 4
`define MEM_STEP_64 8
// Packet field positions in one stored word (parity bit on top)
`define PKT_WIDTH 104
`define PKT_MEM_ADDR_LSB 0
`define PKT_TIMER_ADDR_LSB 32
`define PKT_COUNT_LSB 48
`define PKT_ALT_MEM_LSB 56
`define PKT_WIDE_BIT 88
`define PKT_TSTEP_BIT 89
`define PKT_MSTEP_LSB 90
`define PKT_MODE_LSB 92
`define PKT_DIR_BIT 94
`define PKT_EN_BIT 95
`define PKT_RELOAD_LSB 96
`endif

// File: src/timer_transfer_pkg.sv
// Types shared by the timer transfer unit files.
// Assumes the params header is on the include path.
`include "timer_transfer_params.svh"
package timer_transfer_pkg;
  typedef enum logic [1:0] {mode_one_shot, mode_circular, mode_auto_switch, mode_spare} xfer_mode_type;
  typedef enum logic [1:0] {mem_fixed, mem_step_32, mem_step_64, mem_step_spare} mem_step_type;
  typedef enum logic [2:0] {st_idle, st_read, st_req, st_wait, st_second, st_update} xfer_state_type;
endpackage : timer_transfer_pkg

// File: src/timer_transfer_unit.sv
// Timer transfer unit for one timer module, plus pin-disable and monitor hookups.
// Assumes a simple memory master handshake (req held until ack) on the system side
// and a timer data port that answers in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "timer_transfer_params.svh"
module timer_transfer_unit #(
  parameter int NUM_PACKETS = `NUM_PACKETS,
  parameter int NUM_CH_FIRST = `NUM_CH_FIRST,
  parameter int NUM_CH_SECOND = `NUM_CH_SECOND
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Hookups
  input wire logic [7:0] gp_port_a,
  input wire logic [7:0] gp_port_b,
  input wire logic [NUM_CH_FIRST-1:0] first_timer_out,
  input wire logic [NUM_CH_SECOND-1:0] second_timer_out,
  input wire logic [NUM_CH_FIRST-1:0] first_pin_disable_mask,
  input wire logic [NUM_CH_SECOND-1:0] second_pin_disable_mask,
  input wire logic first_internal_only,
  input wire logic second_internal_only,
  input wire logic [NUM_CH_FIRST-1:0] first_pad_in,
  input wire logic [NUM_CH_SECOND-1:0] second_pad_in,
  output logic [NUM_CH_FIRST-1:0] first_pin_out,
  output logic [NUM_CH_FIRST-1:0] first_pin_oe,
  output logic [NUM_CH_SECOND-1:0] second_pin_out,
  output logic [NUM_CH_SECOND-1:0] second_pin_oe,
  output logic first_clock_comparator_clk1,
  output logic second_clock_comparator_clk1,
  // Transfer requests from the owning timer
  input wire logic [NUM_PACKETS-1:0] timer_transfer_request,
  // Packet configuration port
  input wire logic cfg_wr,
  input wire logic [$clog2(NUM_PACKETS)-1:0] cfg_index,
  input wire logic [`PKT_WIDTH-1:0] cfg_data,
  input wire logic [31:0] mpu_base,
  input wire logic [31:0] mpu_limit,
  // Timer data port
  output logic timer_rd,
  output logic timer_wr,
  output logic [15:0] timer_addr,
  output logic [31:0] timer_wdata,
  input wire logic [31:0] timer_rdata,
  // System memory master
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Status
  output logic [NUM_PACKETS-1:0] request_lost,
  output logic [NUM_PACKETS-1:0] buffer_select,
  output logic [NUM_PACKETS-1:0] packet_done,
  output logic mpu_fault,
  output logic parity_fault,
  input wire logic [NUM_PACKETS-1:0] status_clear
);
  localparam int IW = $clog2(NUM_PACKETS);
  typedef struct packed {
    timer_transfer_pkg::xfer_state_type fsm;
    logic [NUM_PACKETS-1:0] pending;
    logic [NUM_PACKETS-1:0] lost;
    logic [NUM_PACKETS-1:0] bufsel;
    logic [NUM_PACKETS-1:0] done;
    logic [IW-1:0] idx;
    logic [`PKT_WIDTH-1:0] pkt;
    logic second_word;
    logic [31:0] hold;
    logic t_rd;
    logic t_wr;
    logic [15:0] t_addr;
    logic [31:0] t_wdata;
    logic m_req;
    logic m_we;
    logic [31:0] m_addr;
    logic [31:0] m_wdata;
    logic mpu_err;
    logic par_err;
    logic [NUM_CH_FIRST-1:0] p1_out;
    logic [NUM_CH_FIRST-1:0] p1_oe;
    logic [NUM_CH_SECOND-1:0] p2_out;
    logic [NUM_CH_SECOND-1:0] p2_oe;
    logic first_clock_comparator;
    logic second_clock_comparator;
  } unit_state_type;
  unit_state_type state;
  unit_state_type next_state;
  logic [7:0] port_a_sync;
  logic [7:0] port_b_sync;
  logic [NUM_CH_FIRST-1:0] pad1_sync;
  logic [NUM_CH_SECOND-1:0] pad2_sync;
  logic [`PKT_WIDTH-1:0] rd_pkt;
  logic rd_parity_err;
  logic ram_wr;
  logic [IW-1:0] ram_wr_index;
  logic [`PKT_WIDTH-1:0] ram_wr_data;
  logic [IW-1:0] pick;
  logic pick_valid;
  sync2 #(.WIDTH(16 + NUM_CH_FIRST + NUM_CH_SECOND)) pin_sync (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .async_in({gp_port_a, gp_port_b, first_pad_in, second_pad_in}),
    .sync_out({port_a_sync, port_b_sync, pad1_sync, pad2_sync})
  );
  packet_ram #(.DEPTH(NUM_PACKETS), .WIDTH(`PKT_WIDTH)) packets (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .wr_en(ram_wr),
    .wr_index(ram_wr_index),
    .wr_data(ram_wr_data),
    .rd_index(state.idx),
    .rd_data(rd_pkt),
    .parity_error(rd_parity_err)
  );
  // Lowest-numbered pending packet goes first
  always_comb begin
    pick = '0;
    pick_valid = 1'b0;
    for (int i = NUM_PACKETS - 1; i >= 0; i--) begin
      if (state.pending[i]) begin
        pick = i[IW-1:0];
        pick_valid = 1'b1;
      end
    end
  end
  // Write-back of the running packet has priority; a software write in that same cycle is dropped
  assign ram_wr = (state.fsm == timer_transfer_pkg::st_update) || cfg_wr;
  assign ram_wr_index = (state.fsm == timer_transfer_pkg::st_update) ? state.idx : cfg_index;
  assign ram_wr_data = (state.fsm == timer_transfer_pkg::st_update) ? state.pkt : cfg_data;
  always_comb begin
    logic [31:0] step;
    logic [7:0] cnt;
    logic active_alt;
    step = 32'h0;
    cnt = 8'h0;
    active_alt = 1'b0;
    next_state = state;
    for (int i = 0; i < NUM_PACKETS; i++) begin
      if (timer_transfer_request[i]) begin
        if (state.pending[i]) begin
          next_state.lost[i] = 1'b1;
        end
        next_state.pending[i] = 1'b1;
      end else if (status_clear[i]) begin
        next_state.lost[i] = 1'b0;
      end
      if (status_clear[i] && !timer_transfer_request[i]) begin
        next_state.done[i] = 1'b0;
      end
    end
    next_state.t_rd = 1'b0;
    next_state.t_wr = 1'b0;
    // Hookups: pins, fault disable, monitor taps
    for (int c = 0; c < NUM_CH_FIRST; c++) begin
      next_state.p1_out[c] = first_timer_out[c];
      next_state.p1_oe[c] = !(first_pin_disable_mask[c]
        && !port_a_sync[`PIN_DISABLE_BIT_A]);
    end
    for (int c = 0; c < NUM_CH_SECOND; c++) begin
      next_state.p2_out[c] = second_timer_out[c];
      next_state.p2_oe[c] = !(second_pin_disable_mask[c]
        && !port_b_sync[`PIN_DISABLE_BIT_B]);
    end
    next_state.first_clock_comparator = first_internal_only ? first_timer_out[`MONITOR_CH_FIRST]
      : pad1_sync[`MONITOR_CH_FIRST];
    next_state.second_clock_comparator = second_internal_only ? second_timer_out[`MONITOR_CH_SECOND]
      : pad2_sync[`MONITOR_CH_SECOND];
    unique case (state.fsm)
      timer_transfer_pkg::st_idle: begin
        if (pick_valid) begin
          next_state.idx = pick;
          next_state.pending[pick] = timer_transfer_request[pick];
          next_state.fsm = timer_transfer_pkg::st_read;
        end
      end
      timer_transfer_pkg::st_read: begin
        next_state.pkt = rd_pkt;
        next_state.second_word = 1'b0;
        next_state.par_err = state.par_err | rd_parity_err;
        if (rd_parity_err || !rd_pkt[`PKT_EN_BIT]) begin
          next_state.fsm = timer_transfer_pkg::st_idle;
        end else begin
          next_state.fsm = timer_transfer_pkg::st_req;
        end
      end
      timer_transfer_pkg::st_req: begin
        active_alt = state.bufsel[state.idx];
        next_state.t_addr = state.pkt[`PKT_TIMER_ADDR_LSB +: 16]
          + (state.second_word ? 16'h0004 : 16'h0000);
        next_state.m_addr = (active_alt ? state.pkt[`PKT_ALT_MEM_LSB +: 32]
          : state.pkt[`PKT_MEM_ADDR_LSB +: 32]) + (state.second_word ? 32'h4 : 32'h0);
        next_state.m_we = !state.pkt[`PKT_DIR_BIT];
        next_state.t_rd = !state.pkt[`PKT_DIR_BIT];
        if (next_state.m_addr < mpu_base || next_state.m_addr > mpu_limit) begin
          next_state.mpu_err = 1'b1;
          next_state.fsm = timer_transfer_pkg::st_idle;
        end else begin
          next_state.fsm = timer_transfer_pkg::st_wait;
        end
      end
      timer_transfer_pkg::st_wait: begin
        if (!state.m_req) begin
          // Timer read data only matches once the new timer address stands on the port
          next_state.m_req = 1'b1;
          next_state.m_wdata = timer_rdata;
        end else if (mem_ack) begin
          next_state.m_req = 1'b0;
          if (state.pkt[`PKT_DIR_BIT]) begin
            next_state.t_wr = 1'b1;
            next_state.t_wdata = mem_rdata;
          end
          if (state.pkt[`PKT_WIDE_BIT] && !state.second_word) begin
            next_state.second_word = 1'b1;
            next_state.fsm = timer_transfer_pkg::st_req;
          end else begin
            next_state.fsm = timer_transfer_pkg::st_second;
          end
        end
      end
      timer_transfer_pkg::st_second: begin
        step = 32'h0;
        unique case (timer_transfer_pkg::mem_step_type'(state.pkt[`PKT_MSTEP_LSB +: 2]))
          timer_transfer_pkg::mem_fixed: step = 32'h0;
          timer_transfer_pkg::mem_step_32: step = `MEM_STEP_32;
          timer_transfer_pkg::mem_step_64: step = `MEM_STEP_64;
          timer_transfer_pkg::mem_step_spare: step = 32'h0;
        endcase
        if (state.bufsel[state.idx]) begin
          next_state.pkt[`PKT_ALT_MEM_LSB +: 32] = state.pkt[`PKT_ALT_MEM_LSB +: 32] + step;
        end else begin
          next_state.pkt[`PKT_MEM_ADDR_LSB +: 32] = state.pkt[`PKT_MEM_ADDR_LSB +: 32] + step;
        end
        next_state.pkt[`PKT_TIMER_ADDR_LSB +: 16] = state.pkt[`PKT_TIMER_ADDR_LSB +: 16]
          + (state.pkt[`PKT_TSTEP_BIT] ? 16'(`TIMER_STEP_LARGE)
          : 16'(`TIMER_STEP_SMALL));
        cnt = state.pkt[`PKT_COUNT_LSB +: 8] - 8'h01;
        next_state.pkt[`PKT_COUNT_LSB +: 8] = cnt;
        if (cnt == 8'h00) begin
          next_state.done[state.idx] = 1'b1;
          next_state.pkt[`PKT_COUNT_LSB +: 8] = state.pkt[`PKT_RELOAD_LSB +: 8];
          unique case (timer_transfer_pkg::xfer_mode_type'(state.pkt[`PKT_MODE_LSB +: 2]))
            timer_transfer_pkg::mode_one_shot: next_state.pkt[`PKT_EN_BIT] = 1'b0;
            timer_transfer_pkg::mode_circular: next_state.pkt[`PKT_EN_BIT] = 1'b1;
            timer_transfer_pkg::mode_auto_switch: begin
              // Swap buffers so software can refill the idle one
              next_state.bufsel[state.idx] = !state.bufsel[state.idx];
            end
            timer_transfer_pkg::mode_spare: next_state.pkt[`PKT_EN_BIT] = 1'b0;
          endcase
        end
        next_state.fsm = timer_transfer_pkg::st_update;
      end
      timer_transfer_pkg::st_update: begin
        next_state.fsm = timer_transfer_pkg::st_idle;
      end
      default: next_state.fsm = timer_transfer_pkg::st_idle;
    endcase
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= '0;
    end else if (ce) begin
      state <= next_state;
    end
  end
  assign first_pin_out = state.p1_out;
  assign first_pin_oe = state.p1_oe;
  assign second_pin_out = state.p2_out;
  assign second_pin_oe = state.p2_oe;
  assign first_clock_comparator_clk1 = state.first_clock_comparator;
  assign second_clock_comparator_clk1 = state.second_clock_comparator;
  assign timer_rd = state.t_rd;
  assign timer_wr = state.t_wr;
  assign timer_addr = state.t_addr;
  assign timer_wdata = state.t_wdata;
  assign mem_req = state.m_req;
  assign mem_we = state.m_we;
  assign mem_addr = state.m_addr;
  assign mem_wdata = state.m_wdata;
  assign request_lost = state.lost;
  assign buffer_select = state.bufsel;
  assign packet_done = state.done;
  assign mpu_fault = state.mpu_err;
  assign parity_fault = state.par_err;
endmodule : timer_transfer_unit
`default_nettype wire

// File: testbench/mem_partner.sv
// System memory and timer data port model facing the transfer unit.
// Assumes delay of at least 1; memory read data is a pattern of the address.
`timescale 1ns/1ps
`default_nettype none
module mem_partner (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] delay,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  input wire logic [15:0] timer_addr,
  output logic [31:0] timer_rdata
);
  logic [3:0] cnt;
  assign timer_rdata = {16'hc0de, timer_addr};
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 4'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
    end else if (mem_req && !mem_ack && cnt >= delay) begin
      cnt <= 4'h0;
      mem_ack <= 1'b1;
      mem_rdata <= mem_addr ^ 32'ha5a50000;
    end else begin
      // Outside an ack the data bus is not held
      cnt <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : mem_partner
`default_nettype wire

// File: testbench/timer_transfer_unit_bench.sv
// Self-checking bench for the timer transfer unit and its hookups.
// Assumes the memory partner model and the port checker bound below.
`timescale 1ns/1ps
`default_nettype none
module timer_transfer_unit_bench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b0;
  logic [7:0] gp_port_a = 8'hff;
  logic [7:0] gp_port_b = 8'hff;
  logic [31:0] first_timer_out = 32'h0;
  logic [31:0] second_timer_out = 32'h0;
  logic [31:0] first_pin_disable_mask = 32'h0;
  logic [31:0] second_pin_disable_mask = 32'h0;
  logic first_internal_only = 1'b1;
  logic second_internal_only = 1'b1;
  logic [31:0] first_pad_in = 32'h0;
  logic [31:0] second_pad_in = 32'h0;
  logic [31:0] first_pin_out, first_pin_oe, second_pin_out, second_pin_oe;
  logic first_clock_comparator_clk1, second_clock_comparator_clk1;
  logic [7:0] timer_transfer_request = 8'h0;
  logic cfg_wr = 1'b0;
  logic [2:0] cfg_index = 3'h0;
  logic [103:0] cfg_data = 104'h0;
  logic [31:0] mpu_base = 32'h0;
  logic [31:0] mpu_limit = 32'h0fff;
  logic timer_rd, timer_wr, mem_req, mem_we, mem_ack, mpu_fault, parity_fault;
  logic [15:0] timer_addr;
  logic [31:0] timer_wdata, timer_rdata, mem_addr, mem_wdata, mem_rdata;
  logic [7:0] request_lost, buffer_select, packet_done;
  logic [7:0] status_clear = 8'h0;
  logic [3:0] delay = 4'h1;
  int fails = 0;
  int n_tests = 0;
  int n_rd = 0;
  always #50 clk = ~clk;
  always @(posedge clk) if (timer_rd === 1'b1) n_rd++;
  timer_transfer_unit i_dut (.*);
  mem_partner i_mem (.*);
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : tick
  // Flags are {dir, tstep, wide}; the alternate buffer sits 0x800 above the first
  function automatic logic [103:0] pkt(input logic [31:0] ma, input logic [15:0] ta,
    input logic [7:0] cnt, input logic [2:0] fl, input logic [1:0] ms, input logic [1:0] md);
    return {cnt, 1'b1, fl[2], md, ms, fl[1], fl[0], ma + 32'h800, cnt, ta, ma};
  endfunction : pkt
  task automatic put(input int i, input logic [103:0] d);
    cfg_wr = 1'b1;
    cfg_index = 3'(i);
    cfg_data = d;
    tick(1);
    cfg_wr = 1'b0;
    tick(1);
  endtask : put
  task automatic fire(input int n);
    timer_transfer_request[n] = 1'b1;
    tick(1);
    timer_transfer_request[n] = 1'b0;
  endtask : fire
  task automatic word(input string w, input logic [31:0] ea, input logic ewe);
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (!(mem_req === 1'b1 && mem_ack === 1'b1) && k < 40);
    if (k == 40) begin
      fails++;
      complete_run();
    end
    chk({w, " addr"}, mem_addr, ea);
    chk({w, " we"}, 32'(mem_we), 32'(ewe));
  endtask : word
  task automatic t_taps;
    for (int v = 0; v < 2; v++) begin
      first_timer_out = v ? 32'h8000_0000 : 32'h7fff_ffff;
      second_timer_out = v ? 32'h0000_0001 : 32'hffff_fffe;
      tick(1);
      chk("first tap", 32'(first_clock_comparator_clk1), 32'(v));
      chk("second tap", 32'(second_clock_comparator_clk1), 32'(v));
    end
    first_internal_only = 1'b0;
    second_internal_only = 1'b0;
    first_pad_in = 32'h7fff_ffff;
    second_pad_in = 32'hffff_fffe;
    tick(4);
    chk("first pad tap", 32'(first_clock_comparator_clk1), 32'h0);
    chk("second pad tap", 32'(second_clock_comparator_clk1), 32'h0);
  endtask : t_taps
  task automatic t_pins;
    first_pin_disable_mask = 32'h0000_f0f0;
    second_pin_disable_mask = 32'h0f00_0001;
    gp_port_a = 8'hdf;
    gp_port_b = 8'h04;
    tick(4);
    chk("first oe", first_pin_oe, 32'hffff_0f0f);
    chk("first out", first_pin_out, 32'h8000_0000);
    chk("second out", second_pin_out, 32'h0000_0001);
    chk("second oe", second_pin_oe, 32'hffff_ffff);
    gp_port_a = 8'h20;
    gp_port_b = 8'hfb;
    tick(4);
    chk("first oe", first_pin_oe, 32'hffff_ffff);
    chk("second oe", second_pin_oe, 32'hf0ff_fffe);
    gp_port_b = 8'hff;
  endtask : t_pins
  task automatic t_route;
    for (int i = 0; i < 8; i++) put(i, pkt(32'h100 + 32'h10 * i, 16'(i * 64), 8'h1,
      {i == 7, 2'h0}, 2'h1, 2'h0));
    for (int i = 0; i < 8; i++) begin
      fire(i);
      word("route", 32'h100 + 32'h10 * i, i != 7);
      if (i != 7) chk("wdata", mem_wdata, {16'hc0de, 16'(i * 64)});
      tick(1);
      if (i == 7) begin
        chk("timer wr", 32'(timer_wr), 32'h1);
        chk("timer addr", 32'(timer_addr), 32'h1c0);
        chk("timer wdata", timer_wdata, 32'ha5a5_0170);
      end
      tick(5);
      chk("done", 32'(packet_done), 32'(2 ** (i + 1) - 1));
    end
    chk("timer reads", 32'(n_rd), 32'h7);
  endtask : t_route
  task automatic t_step;
    put(5, pkt(32'h200, 16'h10, 8'h2, 3'h3, 2'h2, 2'h1));
    for (int r = 0; r < 2; r++) begin
      fire(5);
      word("wide lo", 32'h200 + 32'h8 * r, 1'b1);
      chk("wide wdata", mem_wdata, {16'hc0de, 16'h10 + 16'(r * 16)});
      word("wide hi", 32'h204 + 32'h8 * r, 1'b1);
      tick(6);
    end
  endtask : t_step
  task automatic t_switch;
    put(6, pkt(32'h300, 16'h0, 8'h1, 3'h0, 2'h1, 2'h2));
    fire(6);
    word("switch a", 32'h300, 1'b1);
    tick(6);
    chk("buffer select", 32'(buffer_select[6]), 32'h1);
    fire(6);
    word("switch b", 32'hb00, 1'b1);
    tick(6);
  endtask : t_switch
  task automatic t_lost;
    status_clear = 8'hff;
    tick(1);
    status_clear = 8'h0;
    chk("done cleared", 32'(packet_done), 32'h0);
    delay = 4'h8;
    put(2, pkt(32'h400, 16'h0, 8'h3, 3'h0, 2'h0, 2'h1));
    fire(2);
    tick(1);
    fire(2);
    tick(1);
    // Picking the packet frees its pending bit, so only the third request is lost
    fire(2);
    tick(1);
    chk("lost", 32'(request_lost), 32'h04);
    word("lost", 32'h400, 1'b1);
    delay = 4'h1;
    tick(6);
    status_clear = 8'h04;
    tick(1);
    status_clear = 8'h0;
    chk("lost cleared", 32'(request_lost), 32'h0);
  endtask : t_lost
  task automatic t_mpu;
    logic seen;
    seen = 1'b0;
    put(4, pkt(32'h2000, 16'h0, 8'h1, 3'h0, 2'h0, 2'h0));
    fire(4);
    repeat (12) begin
      @(negedge clk);
      if (mem_req !== 1'b0) seen = 1'b1;
    end
    chk("blocked req", 32'(seen), 32'h0);
    chk("window fault", 32'(mpu_fault), 32'h1);
    chk("parity", 32'(parity_fault), 32'h0);
  endtask : t_mpu
  initial begin
    tick(4);
    nrst = 1'b1;
    ce = 1'b1;
    tick(1);
    t_taps();
    t_pins();
    t_route();
    t_step();
    t_switch();
    t_lost();
    t_mpu();
    complete_run();
  end
endmodule : timer_transfer_unit_bench
bind timer_transfer_unit timer_transfer_unit_monitor #(.NUM_PACKETS(NUM_PACKETS),
  .NUM_CH_FIRST(NUM_CH_FIRST), .NUM_CH_SECOND(NUM_CH_SECOND)) i_mon (.*);
`default_nettype wire

// File: testbench/timer_transfer_unit_monitor.sv
// Port checker for the timer transfer unit: pin disable, comparator taps, memory master.
// Assumes it is bound to timer_transfer_unit and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module timer_transfer_unit_monitor #(
  parameter int NUM_PACKETS = 8,
  parameter int NUM_CH_FIRST = 32,
  parameter int NUM_CH_SECOND = 32
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] gp_port_a,
  input wire logic [7:0] gp_port_b,
  input wire logic [NUM_CH_FIRST-1:0] first_timer_out,
  input wire logic [NUM_CH_SECOND-1:0] second_timer_out,
  input wire logic [NUM_CH_FIRST-1:0] first_pin_disable_mask,
  input wire logic [NUM_CH_SECOND-1:0] second_pin_disable_mask,
  input wire logic first_internal_only,
  input wire logic second_internal_only,
  input wire logic [NUM_CH_FIRST-1:0] first_pin_oe,
  input wire logic [NUM_CH_SECOND-1:0] second_pin_oe,
  input wire logic first_clock_comparator_clk1,
  input wire logic second_clock_comparator_clk1,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mpu_base,
  input wire logic [31:0] mpu_limit,
  input wire logic [NUM_PACKETS-1:0] request_lost,
  input wire logic [NUM_PACKETS-1:0] status_clear,
  input wire logic mpu_fault,
  input wire logic parity_fault
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Two sync stages plus the output register: four low samples are enough
  first_dis_a:
  assert property ((ce && !gp_port_a[5])[*4]
    |-> (first_pin_oe & $past(first_pin_disable_mask)) == '0)
    else $error("first masked pin driven");
  second_dis_a:
  assert property ((ce && !gp_port_b[2])[*4]
    |-> (second_pin_oe & $past(second_pin_disable_mask)) == '0)
    else $error("second masked pin driven");
  first_tap_a:
  assert property (ce && first_internal_only |=> first_clock_comparator_clk1
    == $past(first_timer_out[31])) else $error("first comparator tap wrong");
  second_tap_a:
  assert property (ce && second_internal_only |=> second_clock_comparator_clk1
    == $past(second_timer_out[0])) else $error("second comparator tap wrong");
  mem_hold_a:
  assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we)
    && $stable(mem_wdata)) else $error("memory request changed before ack");
  word_step_a:
  // Only the second word of a wide transfer can raise the request three edges after an ack
  assert property (mem_req && mem_ack ##1 !mem_req ##1 !mem_req ##1 mem_req
    |-> mem_addr == $past(mem_addr, 3) + 32'h4) else $error("second word not at next address");
  mpu_window_a:
  assert property (mem_req |-> mem_addr >= mpu_base && mem_addr <= mpu_limit)
    else $error("memory access outside window");
  lost_keep_a:
  assert property (ce |=> (($past(request_lost) & ~$past(status_clear)) & ~request_lost) == '0)
    else $error("request lost flag dropped");
  parity_keep_a:
  assert property (parity_fault |=> parity_fault) else $error("parity fault dropped");
  mpu_keep_a:
  assert property (mpu_fault |=> mpu_fault) else $error("window fault dropped");
  cover property (mem_req && mem_ack && mem_we);
  cover property (|request_lost);
  cover property (mpu_fault);
endmodule : timer_transfer_unit_monitor
`default_nettype wire
